// >>> hw/mmpc_regs.vh
/*
 Constants of the meter mode and power control block: APB offsets, field
 positions, mode codes and timing figures.
 Assumes inclusion by bare name from the block's design file.
*/
`ifndef MMPC_REGS_VH
`define MMPC_REGS_VH

// APB register byte offsets
`define MMPC_OFF_CTRL 12'h000
`define MMPC_OFF_STAT 12'h004
`define MMPC_OFF_MODE 12'h008
`define MMPC_OFF_IDLE 12'h00c

// Control register fields
`define MMPC_CTRL_SERIAL 0
`define MMPC_CTRL_RESTORE_ACK 1
`define MMPC_CTRL_RESET 32'h0000_0000

// Status register fields
`define MMPC_ST_APO_EN 0
`define MMPC_ST_SLEEP 1
`define MMPC_ST_SEGTEST 2
`define MMPC_ST_HOLD 3
`define MMPC_ST_RESTORED 4
`define MMPC_ST_SAVED 5

// Measurement mode codes
`define MMPC_M_DCV 5'h00
`define MMPC_M_ACV 5'h01
`define MMPC_M_DCUA 5'h02
`define MMPC_M_ACUA 5'h03
`define MMPC_M_DCMA 5'h04
`define MMPC_M_ACMA 5'h05
`define MMPC_M_DC11A 5'h06
`define MMPC_M_AC11A 5'h07
`define MMPC_M_DCCLAMP 5'h08
`define MMPC_M_ACCLAMP 5'h09
`define MMPC_M_RES 5'h0a
`define MMPC_M_CONT 5'h0b
`define MMPC_M_DIODE 5'h0c
`define MMPC_M_FREQ 5'h0d
`define MMPC_M_CAP 5'h0e
`define MMPC_M_TEMPC 5'h0f
`define MMPC_M_TEMPF 5'h10
`define MMPC_M_ADP 5'h11
`define MMPC_M_NONE 5'h1f

// Timing figures
`define MMPC_CLK_HZ 100000000
`define MMPC_IDLE_LONG_S 1800
`define MMPC_IDLE_SHORT_S 900
`define MMPC_SEGTEST_MS 2000
`define MMPC_MS_PER_S 1000
`define MMPC_BOOT_WAIT 2'h2

`endif

// >>> hw/mmpc_top.v
/*
 Meter mode and power control: mode decode, auto power-off, sleep,
 re-power on and segment test, with an APB register slave.
 Assumes a 100 MHz system clock, buttons already debounced to levels,
 and range/hold/serial logic elsewhere consuming the outputs.
*/
`timescale 1ns/100ps
`include "mmpc_regs.vh"

module mmpc_top #(
  parameter CLK_HZ = `MMPC_CLK_HZ,
  parameter IDLE_LONG_S = `MMPC_IDLE_LONG_S,
  parameter IDLE_SHORT_S = `MMPC_IDLE_SHORT_S,
  parameter SEGTEST_CYC = CLK_HZ / `MMPC_MS_PER_S * `MMPC_SEGTEST_MS
) (
  input wire i_clk_sys,
  input wire i_nrst,
  input wire i_idle_time_select_n,
  input wire i_acdc_select,
  input wire i_function_code_bit1,
  input wire i_function_code_bit2,
  input wire i_function_code_bit3,
  input wire i_function_code_bit4,
  input wire i_key_enable_select,
  input wire i_key,
  input wire i_hold_btn,
  input wire i_other_btn,
  input wire [31:0] i_state,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  output reg [4:0] o_mode,
  output reg [2:0] o_sub,
  output reg o_minus_en,
  output reg o_fn_reset,
  output reg o_fn_reset_all,
  output reg o_auto_power_off_seg,
  output reg o_sleep,
  output reg o_all_seg,
  output reg o_hold_req,
  output reg [31:0] o_saved_state
);

  // Widened product: thirty minutes of cycles overflows 32 bits
  localparam [63:0] IDLE_LONG_CYC = 64'd1 * CLK_HZ * IDLE_LONG_S;
  localparam [63:0] IDLE_SHORT_CYC = 64'd1 * CLK_HZ * IDLE_SHORT_S;
  localparam [1:0] ST_BOOT = 2'h0;
  localparam [1:0] ST_RUN = 2'h1;
  localparam [1:0] ST_SLEEP = 2'h2;

  // Two-flop synchronisers for all pin inputs
  reg [9:0] s1_r;
  reg [9:0] s2_r;
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_r <= 10'h000;
      s2_r <= 10'h000;
    end else begin
      s1_r <= {i_idle_time_select_n, i_acdc_select, i_function_code_bit1,
               i_function_code_bit2, i_function_code_bit3, i_function_code_bit4,
               i_key_enable_select, i_key, i_hold_btn, i_other_btn};
      s2_r <= s1_r;
    end
  end
  wire sel_long = ~s2_r[9];
  wire acdc = s2_r[8];
  wire [3:0] fc = s2_r[7:4];
  wire key_en = s2_r[3];
  wire key = s2_r[2];
  wire hold_b = s2_r[1];
  wire other_b = s2_r[0];

  reg key_d_r;
  reg hold_d_r;
  reg other_d_r;
  reg [3:0] fc_d_r;
  reg acdc_d_r;
  wire key_press = key & ~key_d_r;
  wire hold_press = hold_b & ~hold_d_r;
  wire other_press = other_b & ~other_d_r;
  wire btn_press = key_press | hold_press | other_press;
  wire rotary_chg = (fc != fc_d_r) | (acdc != acdc_d_r);

  // Registers
  reg [1:0] st_r;
  reg [1:0] boot_cnt_r;
  reg [1:0] tog_r;
  reg apo_dis_r;
  reg serial_r;
  reg [63:0] idle_r;
  reg [31:0] seg_cnt_r;
  reg seg_arm_r;
  reg saved_v_r;
  reg restored_r;

  // Mode decode from inputs and toggle count
  reg [4:0] mode_nxt;
  // Sub code: clamp range or adapter index, five values each
  reg [2:0] sub_nxt;
  reg [1:0] tog_mod;
  reg minus_nxt;
  always @* begin
    mode_nxt = `MMPC_M_NONE;
    sub_nxt = 3'h0;
    tog_mod = 2'h1;
    minus_nxt = 1'b0;
    case (fc)
      4'hb: begin
        mode_nxt = (acdc ^ tog_r[0]) ? `MMPC_M_ACV : `MMPC_M_DCV;
        tog_mod = 2'h2;
      end
      4'hd: begin
        mode_nxt = (acdc ^ tog_r[0]) ? `MMPC_M_ACUA : `MMPC_M_DCUA;
        tog_mod = 2'h2;
      end
      4'hf: begin
        mode_nxt = (acdc ^ tog_r[0]) ? `MMPC_M_ACMA : `MMPC_M_DCMA;
        tog_mod = 2'h2;
      end
      4'h0: begin
        mode_nxt = (acdc ^ tog_r[0]) ? `MMPC_M_AC11A : `MMPC_M_DC11A;
        tog_mod = 2'h2;
      end
      4'he, 4'hc, 4'h8, 4'ha, 4'h9: begin
        mode_nxt = (acdc ^ tog_r[0]) ? `MMPC_M_ACCLAMP : `MMPC_M_DCCLAMP;
        sub_nxt = (fc == 4'he) ? 3'h0 : (fc == 4'hc) ? 3'h1 : (fc == 4'h8) ? 3'h2 :
                  (fc == 4'ha) ? 3'h3 : 3'h4;
        tog_mod = 2'h2;
      end
      4'h5: begin
        mode_nxt = tog_r[0] ? `MMPC_M_DIODE : `MMPC_M_RES;
        tog_mod = 2'h2;
      end
      4'h4: begin
        mode_nxt = (acdc ^ tog_r[0]) ? `MMPC_M_TEMPF : `MMPC_M_TEMPC;
        tog_mod = 2'h2;
      end
      default: begin
        if (acdc) begin
          mode_nxt = `MMPC_M_ADP;
          sub_nxt = (fc == 4'h3) ? 3'h0 : (fc == 4'h1) ? 3'h1 : (fc == 4'h7) ? 3'h2 :
                    (fc == 4'h2) ? 3'h3 : 3'h4;
          minus_nxt = key_en;
        end else begin
          case (fc)
            4'h3: begin
              mode_nxt = tog_r[0] ? `MMPC_M_CONT : `MMPC_M_RES;
              tog_mod = 2'h2;
            end
            4'h1: begin
              mode_nxt = tog_r[0] ? `MMPC_M_DIODE : `MMPC_M_CONT;
              tog_mod = 2'h2;
            end
            4'h7: begin
              if (!key_en) begin
                mode_nxt = `MMPC_M_DIODE;
              end else begin
                mode_nxt = (tog_r == 2'h0) ? `MMPC_M_RES :
                           (tog_r == 2'h1) ? `MMPC_M_CONT : `MMPC_M_DIODE;
              end
              tog_mod = 2'h3;
            end
            4'h2: mode_nxt = `MMPC_M_FREQ;
            4'h6: mode_nxt = `MMPC_M_CAP;
            default: mode_nxt = `MMPC_M_NONE;
          endcase
        end
      end
    endcase
  end

  wire apo_active = ~apo_dis_r & ~serial_r;
  wire [63:0] idle_lim = sel_long ? IDLE_LONG_CYC : IDLE_SHORT_CYC;
  wire idle_exp = apo_active && (idle_r >= idle_lim);

  // Main control
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      key_d_r <= 1'b0;
      hold_d_r <= 1'b0;
      other_d_r <= 1'b0;
      fc_d_r <= 4'h0;
      acdc_d_r <= 1'b0;
      st_r <= ST_BOOT;
      boot_cnt_r <= 2'h0;
      tog_r <= 2'h0;
      apo_dis_r <= 1'b0;
      idle_r <= 64'h0;
      seg_cnt_r <= 32'h0;
      seg_arm_r <= 1'b0;
      saved_v_r <= 1'b0;
      restored_r <= 1'b0;
      o_mode <= `MMPC_M_NONE;
      o_sub <= 3'h0;
      o_minus_en <= 1'b0;
      o_fn_reset <= 1'b0;
      o_fn_reset_all <= 1'b0;
      o_auto_power_off_seg <= 1'b0;
      o_sleep <= 1'b1;
      o_all_seg <= 1'b0;
      o_hold_req <= 1'b0;
      o_saved_state <= 32'h0;
    end else begin
      key_d_r <= key;
      hold_d_r <= hold_b;
      other_d_r <= other_b;
      fc_d_r <= fc;
      acdc_d_r <= acdc;
      o_fn_reset <= 1'b0;
      o_fn_reset_all <= 1'b0;
      o_hold_req <= 1'b0;
      case (st_r)
        ST_BOOT: begin
          // Sample straps only once the synchronisers hold the pin levels;
          // edge detectors settle meanwhile, so no false press or rotary change
          if (boot_cnt_r == `MMPC_BOOT_WAIT) begin
            apo_dis_r <= other_b;
            seg_arm_r <= hold_b;
            seg_cnt_r <= 32'h0;
            st_r <= ST_RUN;
          end else begin
            boot_cnt_r <= boot_cnt_r + 2'h1;
          end
        end
        ST_RUN: begin
          o_sleep <= 1'b1;
          if (seg_arm_r) begin
            if (!hold_b) begin
              seg_arm_r <= 1'b0;
            end else if (seg_cnt_r >= SEGTEST_CYC - 1) begin
              o_all_seg <= 1'b1;
              seg_arm_r <= 1'b0;
            end else begin
              seg_cnt_r <= seg_cnt_r + 32'h1;
            end
          end else if (o_all_seg && hold_press) begin
            o_all_seg <= 1'b0;
          end
          if (rotary_chg) begin
            tog_r <= 2'h0;
            o_fn_reset_all <= 1'b1;
          end else if (key_press && key_en) begin
            tog_r <= (tog_r + 2'h1 >= tog_mod) ? 2'h0 : tog_r + 2'h1;
            o_fn_reset <= 1'b1;
          end
          if (!key_en) begin
            tog_r <= 2'h0;
          end
          if (btn_press || rotary_chg || !apo_active) begin
            idle_r <= 64'h0;
          end else if (idle_exp) begin
            o_saved_state <= i_state;
            saved_v_r <= 1'b1;
            o_sleep <= 1'b0;
            st_r <= ST_SLEEP;
          end else begin
            idle_r <= idle_r + 64'h1;
          end
        end
        ST_SLEEP: begin
          idle_r <= 64'h0;
          if (rotary_chg) begin
            saved_v_r <= 1'b0;
            o_saved_state <= 32'h0;
            tog_r <= 2'h0;
            o_fn_reset_all <= 1'b1;
            o_sleep <= 1'b1;
            st_r <= ST_RUN;
          end else if (btn_press) begin
            o_hold_req <= 1'b1;
            restored_r <= 1'b1;
            o_sleep <= 1'b1;
            st_r <= ST_RUN;
          end
        end
        default: st_r <= ST_BOOT;
      endcase
      if (restored_r && rotary_chg) begin
        restored_r <= 1'b0;
      end
      o_mode <= mode_nxt;
      o_sub <= sub_nxt;
      o_minus_en <= minus_nxt;
      o_auto_power_off_seg <= apo_active;
    end
  end

  // APB slave, zero wait states
  wire apb_wr = i_psel & i_penable & i_pwrite;
  wire apb_rd_setup = i_psel & ~i_penable & ~i_pwrite;
  wire mapped = (i_paddr == `MMPC_OFF_CTRL) || (i_paddr == `MMPC_OFF_STAT) ||
                (i_paddr == `MMPC_OFF_MODE) || (i_paddr == `MMPC_OFF_IDLE);
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      serial_r <= 1'b0;
      o_prdata <= 32'h0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~mapped;
      if (apb_wr && i_paddr == `MMPC_OFF_CTRL) begin
        serial_r <= i_pwdata[`MMPC_CTRL_SERIAL];
      end
      if (apb_rd_setup) begin
        case (i_paddr)
          `MMPC_OFF_CTRL: o_prdata <= {31'h0, serial_r};
          `MMPC_OFF_STAT: o_prdata <= {26'h0, saved_v_r, restored_r, o_hold_req,
                                       o_all_seg, ~o_sleep, apo_active};
          `MMPC_OFF_MODE: o_prdata <= {23'h0, o_minus_en, o_sub, o_mode};
          `MMPC_OFF_IDLE: o_prdata <= idle_r[31:0];
          default: o_prdata <= 32'h0;
        endcase
      end
    end
  end

endmodule // mmpc_top

// >>> bench/mmpc_props.sv
/*
 Checker for mmpc_top: mode decode, power-off, wake and segment test.
 Assumes a bind into mmpc_top, one clock domain.
*/
`timescale 1ns/100ps
module mmpc_props (
  input wire i_clk_sys,
  input wire i_nrst,
  input wire i_acdc_select,
  input wire i_function_code_bit1,
  input wire i_function_code_bit2,
  input wire i_function_code_bit3,
  input wire i_function_code_bit4,
  input wire i_key_enable_select,
  input wire i_hold_btn,
  input wire i_other_btn,
  input wire [4:0] o_mode,
  input wire [2:0] o_sub,
  input wire o_minus_en,
  input wire o_fn_reset,
  input wire o_fn_reset_all,
  input wire o_auto_power_off_seg,
  input wire o_sleep,
  input wire o_all_seg,
  input wire o_hold_req
);
  wire [3:0] fc = {i_function_code_bit1, i_function_code_bit2, i_function_code_bit3,
    i_function_code_bit4};
  reg [4:0] ken_r;
  // Recent key enable history
  always @(posedge i_clk_sys) begin
    ken_r <= {ken_r[3:0], i_key_enable_select};
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  property p_off_enabled;
    $fell(o_sleep) |-> $past(o_auto_power_off_seg);
  endproperty
  a_off_enabled: assert property (p_off_enabled) else $error("power-off while disabled");
  property p_segtest_end;
    o_all_seg && $rose(i_hold_btn) |-> ##[1:4] !o_all_seg;
  endproperty
  a_segtest_end: assert property (p_segtest_end) else $error("segment test kept");
  property p_rotary_wake;
    !o_sleep && fc != $past(fc) |-> ##[1:4] o_fn_reset_all;
  endproperty
  a_rotary_wake: assert property (p_rotary_wake) else $error("no rotary reset");
  property p_button_wake;
    !o_sleep && $rose(i_other_btn) |-> ##[1:4] o_hold_req;
  endproperty
  a_button_wake: assert property (p_button_wake) else $error("no hold request");
  property p_dcv;
    (fc == 4'hb && !i_acdc_select && !i_key_enable_select && o_sleep) [*6] |-> o_mode == 5'h00;
  endproperty
  a_dcv: assert property (p_dcv) else $error("voltage decode wrong");
  property p_clamp;
    (fc == 4'he && i_acdc_select && !i_key_enable_select && o_sleep) [*6]
      |-> o_mode == 5'h09 && o_sub == 3'h0;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp decode wrong");
  property p_key_ignored;
    o_fn_reset |-> |ken_r[4:1];
  endproperty
  a_key_ignored: assert property (p_key_ignored) else $error("key used while disabled");
  property p_minus;
    o_minus_en |-> o_mode == 5'h11 && |ken_r[4:1];
  endproperty
  a_minus: assert property (p_minus) else $error("minus sign not suppressed");
endmodule // mmpc_props

bind mmpc_top mmpc_props u_mmpc_props (
  .i_clk_sys(i_clk_sys),
  .i_nrst(i_nrst),
  .i_acdc_select(i_acdc_select),
  .i_function_code_bit1(i_function_code_bit1),
  .i_function_code_bit2(i_function_code_bit2),
  .i_function_code_bit3(i_function_code_bit3),
  .i_function_code_bit4(i_function_code_bit4),
  .i_key_enable_select(i_key_enable_select),
  .i_hold_btn(i_hold_btn),
  .i_other_btn(i_other_btn),
  .o_mode(o_mode),
  .o_sub(o_sub),
  .o_minus_en(o_minus_en),
  .o_fn_reset(o_fn_reset),
  .o_fn_reset_all(o_fn_reset_all),
  .o_auto_power_off_seg(o_auto_power_off_seg),
  .o_sleep(o_sleep),
  .o_all_seg(o_all_seg),
  .o_hold_req(o_hold_req)
);

// >>> bench/mmpc_panel.sv
/*
 Rotary switch, push buttons and idle strap facing mmpc_top.
 Assumes the bench calls its tasks; levels change after a rising edge.
*/
`timescale 1ns/100ps
module mmpc_panel (
  input wire i_clk_sys,
  output logic o_idle_time_select_n,
  output logic o_acdc_select,
  output logic [3:0] o_fc,
  output logic o_key_enable_select,
  output logic [2:0] o_btn
);
  initial begin
    o_idle_time_select_n = 1'b1;
    o_acdc_select = 1'b0;
    o_fc = 4'hb;
    o_key_enable_select = 1'b0;
    o_btn = 3'h0;
  end
  task set(input [1:0] ks, input [3:0] fc);
    @(posedge i_clk_sys);
    o_key_enable_select <= ks[1];
    o_acdc_select <= ks[0];
    o_fc <= fc;
  endtask
  // Buttons: bit0 key, bit1 hold, bit2 other
  task lvl(input [2:0] b);
    @(posedge i_clk_sys);
    o_btn <= b;
  endtask
  task push(input [2:0] b);
    lvl(b);
    repeat (4) @(posedge i_clk_sys);
    lvl(3'h0);
    repeat (4) @(posedge i_clk_sys);
  endtask
  task strap(input v);
    @(posedge i_clk_sys);
    o_idle_time_select_n <= v;
  endtask
endmodule // mmpc_panel

// >>> bench/mmpc_bench.sv
/*
 Self-checking bench for mmpc_top with shortened counts.
 Assumes CLK_HZ of 10: idle limits of 9000 and 18000 cycles.
*/
`timescale 1ns/100ps
module mmpc_bench;
  logic i_clk_sys = 1'b0;
  logic i_nrst;
  logic i_psel;
  logic i_penable;
  logic i_pwrite;
  logic er;
  logic fr = 1'b0;
  logic hq = 1'b0;
  logic fa = 1'b0;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata;
  logic [31:0] i_state;
  logic [31:0] rd;
  wire [31:0] o_prdata, o_saved_state;
  wire [4:0] o_mode;
  wire [2:0] o_sub;
  wire o_pready, o_pslverr, o_minus_en, o_fn_reset, o_fn_reset_all, o_auto_power_off_seg;
  wire o_sleep, o_all_seg, o_hold_req, i_idle_time_select_n, i_acdc_select, i_key_enable_select;
  wire [3:0] fc;
  wire [2:0] btn;
  int n_mismatch = 0, check_count = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  mmpc_panel u_mmpc_panel (.i_clk_sys(i_clk_sys), .o_idle_time_select_n(i_idle_time_select_n),
    .o_acdc_select(i_acdc_select), .o_fc(fc), .o_key_enable_select(i_key_enable_select),
    .o_btn(btn));
  mmpc_top #(.CLK_HZ(10), .SEGTEST_CYC(20)) u_mmpc_top (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_idle_time_select_n(i_idle_time_select_n),
    .i_acdc_select(i_acdc_select),
    .i_function_code_bit1(fc[3]),
    .i_function_code_bit2(fc[2]),
    .i_function_code_bit3(fc[1]),
    .i_function_code_bit4(fc[0]),
    .i_key_enable_select(i_key_enable_select),
    .i_key(btn[0]),
    .i_hold_btn(btn[1]),
    .i_other_btn(btn[2]),
    .i_state(i_state),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_mode(o_mode),
    .o_sub(o_sub),
    .o_minus_en(o_minus_en),
    .o_fn_reset(o_fn_reset),
    .o_fn_reset_all(o_fn_reset_all),
    .o_auto_power_off_seg(o_auto_power_off_seg),
    .o_sleep(o_sleep),
    .o_all_seg(o_all_seg),
    .o_hold_req(o_hold_req),
    .o_saved_state(o_saved_state)
  );
  // Sticky copies of one-cycle pulses
  always @(posedge i_clk_sys) begin
    if (o_fn_reset === 1'b1) fr <= 1'b1;
    if (o_fn_reset_all === 1'b1) fa <= 1'b1;
    if (o_hold_req === 1'b1) hq <= 1'b1;
  end
  task chk(input [31:0] seen, input [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    @(posedge i_clk_sys);
    // Only the watchdog ends a wait that never sees ready
    while (o_pready !== 1'b1) @(posedge i_clk_sys);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task rst(input [2:0] b, input v);
    u_mmpc_panel.lvl(b);
    u_mmpc_panel.strap(v);
    i_nrst <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    repeat (30) @(posedge i_clk_sys);
  endtask
  task md(input [1:0] ks, input [3:0] f, input [4:0] m, input [2:0] s);
    u_mmpc_panel.set(ks, f);
    repeat (6) @(posedge i_clk_sys);
    chk(o_mode, m);
    if (m == 5'h08 || m == 5'h09 || m == 5'h11) chk(o_sub, s);
    chk(o_minus_en, ks[1] && m == 5'h11);
  endtask
  task end_of_test;
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    // Tests take about 42k cycles; give up at 60k
    #600000;
    n_mismatch++;
    end_of_test;
  end
  initial begin
    i_nrst = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 12'h000;
    i_pwdata = 32'h0;
    i_state = 32'h0;
    rst(3'h2, 1'b1);
    chk(fa, 1'b0);
    chk(o_all_seg, 1'b1);
    chk(o_auto_power_off_seg, 1'b1);
    u_mmpc_panel.lvl(3'h0);
    u_mmpc_panel.push(3'h2);
    chk(o_all_seg, 1'b0);
    md(2'h1, 4'hb, 5'h01, 2'h0);
    md(2'h0, 4'h4, 5'h0f, 2'h0);
    chk(fa, 1'b1);
    md(2'h1, 4'h4, 5'h10, 2'h0);
    md(2'h1, 4'he, 5'h09, 2'h0);
    md(2'h0, 4'hc, 5'h08, 2'h1);
    md(2'h1, 4'h8, 5'h09, 2'h2);
    md(2'h0, 4'ha, 5'h08, 2'h3);
    md(2'h0, 4'h9, 5'h08, 3'h4);
    md(2'h2, 4'hd, 5'h02, 2'h0);
    md(2'h3, 4'hf, 5'h05, 2'h0);
    md(2'h2, 4'h0, 5'h06, 2'h0);
    md(2'h2, 4'h3, 5'h0a, 2'h0);
    md(2'h2, 4'h1, 5'h0b, 2'h0);
    md(2'h2, 4'h2, 5'h0d, 2'h0);
    md(2'h2, 4'h6, 5'h0e, 2'h0);
    md(2'h3, 4'h5, 5'h0a, 2'h0);
    md(2'h3, 4'h3, 5'h11, 2'h0);
    md(2'h3, 4'h7, 5'h11, 2'h2);
    md(2'h1, 4'h1, 5'h11, 2'h1);
    md(2'h1, 4'h6, 5'h11, 3'h4);
    md(2'h2, 4'hb, 5'h00, 2'h0);
    u_mmpc_panel.push(3'h1);
    chk(o_mode, 5'h01);
    chk(fr, 1'b1);
    md(2'h2, 4'h7, 5'h0a, 2'h0);
    u_mmpc_panel.push(3'h1);
    chk(o_mode, 5'h0b);
    u_mmpc_panel.push(3'h1);
    chk(o_mode, 5'h0c);
    md(2'h0, 4'h7, 5'h0c, 2'h0);
    u_mmpc_panel.push(3'h1);
    chk(o_mode, 5'h0c);
    apb(1'b1, 12'h000, 32'h1);
    repeat (3) @(posedge i_clk_sys);
    chk(o_auto_power_off_seg, 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[0], 1'b0);
    apb(1'b0, 12'h010, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, 12'h000, 32'h0);
    repeat (3) @(posedge i_clk_sys);
    chk(o_auto_power_off_seg, 1'b1);
    i_state <= 32'h5a5a_1234;
    u_mmpc_panel.push(3'h4);
    repeat (5000) @(posedge i_clk_sys);
    u_mmpc_panel.push(3'h4);
    repeat (8000) @(posedge i_clk_sys);
    chk(o_sleep, 1'b1);
    repeat (1300) @(posedge i_clk_sys);
    chk(o_sleep, 1'b0);
    chk(o_saved_state, 32'h5a5a_1234);
    u_mmpc_panel.push(3'h4);
    chk(o_sleep, 1'b1);
    chk(hq, 1'b1);
    chk(o_saved_state, 32'h5a5a_1234);
    rst(3'h0, 1'b0);
    repeat (17000) @(posedge i_clk_sys);
    chk(o_sleep, 1'b1);
    repeat (1300) @(posedge i_clk_sys);
    chk(o_sleep, 1'b0);
    chk(o_saved_state, 32'h5a5a_1234);
    md(2'h0, 4'h3, 5'h0a, 2'h0);
    chk(o_sleep, 1'b1);
    chk(o_saved_state, 32'h0);
    rst(3'h4, 1'b1);
    chk(o_auto_power_off_seg, 1'b0);
    u_mmpc_panel.lvl(3'h0);
    repeat (9300) @(posedge i_clk_sys);
    chk(o_sleep, 1'b1);
    end_of_test;
  end
endmodule // mmpc_bench
